// ---- vbd_decimator.sv ----
// decimation chain: modulator bit stream to 16-bit pcm words
`timescale 1ns/1ps

// Overview of operation
// - one output word is made per 125 modulator bits.
// - all timing follows os_tick, so the response scales with the sample rate up to 24 kHz.
// - the input is one modulator bit per oversampling tick, read as +1 or -1.
// - the first stage is three cascaded 25-sample moving sums.
// - the first stage emits one word per 25 oversampling ticks.
// - the second stage is a seventh-order recursive low-pass that decimates by five.
// - the second stage attenuates the noise band above the voice band before decimation.
// - results leave as 16-bit two's complement words.
// - external_gain_select low picks the preamp mode, high the external amplifier mode.
// - overload clips to 0x7FFF or 0x8000 and never wraps.
module vbd_decimator (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            nrst,
    // modulator stream
    input  wire logic            os_tick,
    input  wire logic            mod_bit,
    // analog mode strap
    input  wire logic            external_gain_select,
    output vbd_pkg::vbd_mode_t   input_mode,
    // pcm output stream
    output logic                 pcm_valid,
    input  wire logic            pcm_ready,
    output vbd_pkg::vbd_word_t   pcm_word,
    output logic                 pcm_strobe,
    output logic                 pcm_overrun
);

    // sinc-cubic stage state
    vbd_pkg::vbd_cic_t            int_r   [3];
    vbd_pkg::vbd_cic_t            int_nxt [3];
    vbd_pkg::vbd_cic_t            dly_r   [3];
    vbd_pkg::vbd_cic_t            dly_nxt [3];
    vbd_pkg::vbd_cic_t            cmb     [3];
    vbd_pkg::vbd_cic_t            cic_out_r;
    vbd_pkg::vbd_cic_t            cic_out_nxt;
    vbd_pkg::vbd_cic_t            in_step;
    logic [vbd_pkg::CIC_CNT_W-1:0] cic_cnt_r;
    logic [vbd_pkg::CIC_CNT_W-1:0] cic_cnt_nxt;
    logic                         cic_tick;
    logic                         mid_vld_r;
    logic                         mid_vld_nxt;

    // low-pass stage state
    vbd_pkg::vbd_acc_t            stg_in  [vbd_pkg::LPF_ORDER];
    vbd_pkg::vbd_acc_t            stg_r   [vbd_pkg::LPF_ORDER];
    logic [vbd_pkg::LPF_CNT_W-1:0] lpf_cnt_r;
    logic [vbd_pkg::LPF_CNT_W-1:0] lpf_cnt_nxt;
    logic                         out_tick;
    vbd_pkg::vbd_acc_t            y_scaled;
    vbd_pkg::vbd_word_t           new_word;

    // output buffer and misc state
    vbd_pkg::vbd_word_t           mem_r [vbd_pkg::BUF_DEPTH];
    logic                         wr_ptr_r;
    logic                         wr_ptr_nxt;
    logic                         rd_ptr_r;
    logic                         rd_ptr_nxt;
    logic [vbd_pkg::BUF_CNT_W-1:0] cnt_r;
    logic [vbd_pkg::BUF_CNT_W-1:0] cnt_nxt;
    logic                         buf_in_ready;
    logic                         push;
    logic                         pop;
    logic                         strobe_nxt;
    logic                         overrun_nxt;
    vbd_pkg::vbd_mode_t           mode_nxt;

    // one modulator bit maps to +1 / -1 at the integrator input
    assign in_step  = mod_bit ? vbd_pkg::CIC_ONE : -vbd_pkg::CIC_ONE;
    assign cic_tick = os_tick && (cic_cnt_r == vbd_pkg::CIC_LAST);

    // comb section: wraparound arithmetic is exact as long as the width holds the full gain
    assign cmb[0] = int_r[2] - dly_r[0];
    assign cmb[1] = cmb[0] - dly_r[1];
    assign cmb[2] = cmb[1] - dly_r[2];

    // sinc-cubic next state: integrate every tick, comb and decimate every 25th
    always_comb begin
        int_nxt     = int_r;
        dly_nxt     = dly_r;
        cic_out_nxt = cic_out_r;
        cic_cnt_nxt = cic_cnt_r;
        mid_vld_nxt = cic_tick;
        if (os_tick) begin
            int_nxt[0]  = int_r[0] + in_step;
            int_nxt[1]  = int_r[1] + int_r[0];
            int_nxt[2]  = int_r[2] + int_r[1];
            cic_cnt_nxt = cic_tick ? '0 : cic_cnt_r + 1'b1;
        end
        if (cic_tick) begin
            dly_nxt[0]  = int_r[2];
            dly_nxt[1]  = cmb[0];
            dly_nxt[2]  = cmb[1];
            cic_out_nxt = cmb[2];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            int_r     <= '{default: '0};
            dly_r     <= '{default: '0};
            cic_out_r <= '0;
            cic_cnt_r <= '0;
            mid_vld_r <= 1'b0;
        end else begin
            int_r     <= int_nxt;
            dly_r     <= dly_nxt;
            cic_out_r <= cic_out_nxt;
            cic_cnt_r <= cic_cnt_nxt;
            mid_vld_r <= mid_vld_nxt;
        end
    end

    // seven one-pole sections in cascade; shift-only taps keep the rate scaling coefficient-free
    assign stg_in[0] = vbd_pkg::vbd_acc_t'(cic_out_r) <<< vbd_pkg::IIR_FRAC;
    genvar gi;
    generate
        for (gi = 0; gi < vbd_pkg::LPF_ORDER; gi++) begin : g_pole
            vbd_pkg::vbd_acc_t diff;
            vbd_pkg::vbd_acc_t stg_nxt;
            if (gi > 0) begin : g_link
                assign stg_in[gi] = stg_r[gi-1];
            end
            // each pole runs only at the intermediate rate, so noise above 3.4 kHz is cut
            always_comb begin
                diff    = stg_in[gi] - stg_r[gi];
                stg_nxt = mid_vld_r ? stg_r[gi] + (diff >>> vbd_pkg::LPF_SHIFT)
                                    : stg_r[gi];
            end
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    stg_r[gi] <= '0;
                end else begin
                    stg_r[gi] <= stg_nxt;
                end
            end
        end
    endgenerate

    // decimate-by-five counter on the intermediate rate
    assign out_tick = mid_vld_r && (lpf_cnt_r == vbd_pkg::LPF_LAST);
    always_comb begin
        lpf_cnt_nxt = lpf_cnt_r;
        if (mid_vld_r) begin
            lpf_cnt_nxt = out_tick ? '0 : lpf_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            lpf_cnt_r <= '0;
        end else begin
            lpf_cnt_r <= lpf_cnt_nxt;
        end
    end

    // scale to pcm and hard-limit: a wrapped word would turn overload into full-scale noise
    assign y_scaled = stg_r[vbd_pkg::LPF_ORDER-1] >>> vbd_pkg::OUT_SH;
    always_comb begin
        new_word.sat = 1'b0;
        new_word.pcm = y_scaled[vbd_pkg::PCM_W-1:0];
        if (y_scaled > vbd_pkg::vbd_acc_t'(vbd_pkg::PCM_MAX)) begin
            new_word.sat = 1'b1;
            new_word.pcm = vbd_pkg::PCM_MAX;
        end else if (y_scaled < vbd_pkg::vbd_acc_t'(vbd_pkg::PCM_MIN)) begin
            new_word.sat = 1'b1;
            new_word.pcm = vbd_pkg::PCM_MIN;
        end
    end

    // two-entry buffer; a word that meets a full buffer is counted as an overrun
    assign buf_in_ready = (cnt_r != vbd_pkg::BUF_FULL);
    assign push         = out_tick && buf_in_ready;
    assign pop          = pcm_valid && pcm_ready;
    assign pcm_valid    = (cnt_r != '0);
    assign pcm_word     = mem_r[rd_ptr_r];

    always_comb begin
        wr_ptr_nxt  = push ? ~wr_ptr_r : wr_ptr_r;
        rd_ptr_nxt  = pop ? ~rd_ptr_r : rd_ptr_r;
        cnt_nxt     = cnt_r + {1'b0, push} - {1'b0, pop};
        strobe_nxt  = out_tick;
        overrun_nxt = out_tick && !buf_in_ready;
        mode_nxt    = external_gain_select ? vbd_pkg::VBD_MODE_EXTAMP
                                           : vbd_pkg::VBD_MODE_PREAMP;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_r    <= 1'b0;
            rd_ptr_r    <= 1'b0;
            cnt_r       <= '0;
            pcm_strobe  <= 1'b0;
            pcm_overrun <= 1'b0;
            input_mode  <= vbd_pkg::VBD_MODE_PREAMP;
            mem_r       <= '{default: '0};
        end else begin
            wr_ptr_r    <= wr_ptr_nxt;
            rd_ptr_r    <= rd_ptr_nxt;
            cnt_r       <= cnt_nxt;
            pcm_strobe  <= strobe_nxt;
            pcm_overrun <= overrun_nxt;
            input_mode  <= mode_nxt;
            if (push) begin
                mem_r[wr_ptr_r] <= new_word;
            end
        end
    end

    // checks, all quiet while reset is held
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // helper: oversampling ticks seen since the last strobe
    logic [vbd_pkg::SINCE_W-1:0] since_r;
    logic                        seen_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            since_r <= '0;
            seen_r  <= 1'b0;
        end else begin
            since_r <= pcm_strobe ? vbd_pkg::SINCE_W'(os_tick)
                                  : since_r + vbd_pkg::SINCE_W'(os_tick);
            seen_r  <= seen_r | pcm_strobe;
        end
    end

    // strobe timing: a new word is announced one clock after the output tick
    sequence s_word_ready;
        out_tick ##1 pcm_strobe;
    endsequence

    // a word that meets a full buffer is dropped, and both pulses come together
    sequence s_word_dropped;
        (out_tick && !buf_in_ready) ##1 (pcm_strobe && pcm_overrun);
    endsequence

    // a word written into the buffer is offered to the receiver on the next clock
    sequence s_word_offered;
        push ##1 pcm_valid;
    endsequence

    a_strobe_spacing: assert property (
        pcm_strobe && seen_r |-> since_r == vbd_pkg::SINCE_W'(vbd_pkg::OS_RATIO))
        else $error("strobe spacing is not 125 oversampling ticks");
    a_strobe_single: assert property (pcm_strobe |=> !pcm_strobe)
        else $error("strobe lasted more than one cycle");
    a_strobe_cause: assert property (out_tick |-> s_word_ready)
        else $error("output tick did not raise the strobe");
    a_overrun_flag: assert property (
        out_tick && !buf_in_ready |-> s_word_dropped)
        else $error("dropped word not flagged with its strobe");
    a_overrun_cause: assert property (
        pcm_overrun |-> pcm_strobe && $past(cnt_r) == vbd_pkg::BUF_FULL)
        else $error("overrun flagged while the buffer had room");

    // sinc-cubic stage: unit steps in, bounded words out on every 25th tick
    a_bit_step: assert property (
        os_tick |=> (int_r[0] - $past(int_r[0]) == vbd_pkg::CIC_ONE)
        || ($past(int_r[0]) - int_r[0] == vbd_pkg::CIC_ONE))
        else $error("integrator did not move by one bit");
    a_cic_range: assert property (
        mid_vld_r |-> cic_out_r <= vbd_pkg::CIC_W'(vbd_pkg::CIC_FULL)
        && cic_out_r >= -vbd_pkg::CIC_W'(vbd_pkg::CIC_FULL))
        else $error("sinc-cubic output beyond full gain");
    a_cic_rate: assert property (
        mid_vld_r |-> $past(os_tick) && $past(cic_cnt_r) == vbd_pkg::CIC_LAST)
        else $error("intermediate word not on the 25th tick");

    // low-pass stage and input mode
    a_lpf_hold: assert property (!mid_vld_r |=> $stable(stg_r[vbd_pkg::LPF_ORDER-1]))
        else $error("low-pass state moved off the intermediate rate");
    a_mode_follow: assert property (
        $changed(external_gain_select)
        |=> input_mode == ($past(external_gain_select) ? vbd_pkg::VBD_MODE_EXTAMP
                                                       : vbd_pkg::VBD_MODE_PREAMP))
        else $error("input mode does not follow the gain select pin");

    // clipping: a clipped word sits on the rail of the filter result's sign
    a_sat_clip: assert property (
        push && new_word.sat |->
        new_word.pcm == vbd_pkg::PCM_MAX || new_word.pcm == vbd_pkg::PCM_MIN)
        else $error("clipped word is not a limit value");
    a_sat_sign: assert property (
        push && new_word.sat |->
        (new_word.pcm == vbd_pkg::PCM_MAX) == !y_scaled[vbd_pkg::IIR_W-1])
        else $error("clip went to the wrong rail");
    a_pcm_exact: assert property (
        push && !new_word.sat |-> new_word.pcm == y_scaled[vbd_pkg::PCM_W-1:0])
        else $error("unclipped word differs from the filter result");

    // output buffer: words already held are neither lost nor reordered while the receiver stalls
    a_word_offered: assert property (push |-> s_word_offered)
        else $error("pushed word not offered to the receiver");
    a_drain_next: assert property (pop && cnt_r == vbd_pkg::BUF_FULL |=> pcm_valid)
        else $error("second buffered word not offered after a pop");
    a_buf_stall: assert property (pcm_valid && !pcm_ready |=> pcm_valid && $stable(pcm_word))
        else $error("buffered word lost under stall");
    a_buf_bound: assert property (cnt_r <= vbd_pkg::BUF_FULL)
        else $error("buffer count above depth");

endmodule

// ---- vbd_pkg.sv ----
// shared constants and types of the voice band decimation chain
package vbd_pkg;
    // rates and ratios
    localparam int OS_RATIO    = 125;
    localparam int CIC_DECIM   = 25;
    localparam int LPF_DECIM   = 5;
    localparam int LPF_ORDER   = 7;
    localparam int NOM_FS_HZ   = 8000;
    localparam int MAX_FS_HZ   = 24000;
    localparam int NOM_FOS_HZ  = NOM_FS_HZ * OS_RATIO;
    localparam int NOM_MID_HZ  = NOM_FOS_HZ / CIC_DECIM;

    // datapath widths and scaling
    localparam int CIC_W       = 18;
    localparam int IIR_W       = 28;
    localparam int IIR_FRAC    = 8;
    localparam int OUT_SH      = 7;
    localparam int PCM_W       = 16;
    localparam int LPF_SHIFT   = 2;
    localparam int CIC_FULL    = CIC_DECIM * CIC_DECIM * CIC_DECIM;
    localparam int BUF_DEPTH   = 2;

    // counter widths and terminal counts
    localparam int CIC_CNT_W   = 5;
    localparam int LPF_CNT_W   = 3;
    localparam int SINCE_W     = 8;
    localparam int BUF_CNT_W   = 2;
    localparam logic [CIC_CNT_W-1:0] CIC_LAST = CIC_CNT_W'(CIC_DECIM - 1);
    localparam logic [LPF_CNT_W-1:0] LPF_LAST = LPF_CNT_W'(LPF_DECIM - 1);
    localparam logic [BUF_CNT_W-1:0] BUF_FULL = BUF_CNT_W'(BUF_DEPTH);

    typedef logic signed [CIC_W-1:0] vbd_cic_t;
    typedef logic signed [IIR_W-1:0] vbd_acc_t;
    typedef logic signed [PCM_W-1:0] vbd_pcm_t;

    // saturation limits of the pcm word
    localparam vbd_pcm_t PCM_MAX = 16'sh7FFF;
    localparam vbd_pcm_t PCM_MIN = 16'sh8000;
    localparam vbd_cic_t CIC_ONE = 18'sh00001;

    // analog input mode fed to the modulator front end
    typedef enum logic {
        VBD_MODE_PREAMP,
        VBD_MODE_EXTAMP
    } vbd_mode_t;

    // one output word with its clipping flag
    typedef struct packed {
        logic     sat;
        vbd_pcm_t pcm;
    } vbd_word_t;
endpackage

// ---- vbd_partner.sv ----
// partner model: modulator bit source and pcm word receiver
`timescale 1ns/1ps

module vbd_partner (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               nrst,
    // controls from the bench
    input  wire logic [7:0]         period,
    input  wire logic [1:0]         pattern,
    input  wire logic               stall,
    // modulator stream
    output logic                    os_tick,
    output logic                    mod_bit,
    // pcm receiver
    input  wire logic               pcm_valid,
    output logic                    pcm_ready,
    input  wire vbd_pkg::vbd_word_t pcm_word,
    output vbd_pkg::vbd_word_t      last_word,
    output int                      pops
);
    logic [7:0] phase;
    logic       bit_v;
    logic       rst_v;
    logic [7:0] per_v;
    logic [1:0] pat_v;

    // the receiver stalls only when the bench asks for it or holds reset
    assign pcm_ready = nrst && !stall;

    initial begin
        os_tick = 1'b0;
        mod_bit = 1'b0;
        bit_v = 1'b0;
        phase = 8'h00;
        pops = 0;
        last_word = '0;
    end

    // one bit per tick; between ticks the line shows the inverse so a stray sample shows up
    always begin
        @(posedge clk);
        // controls are read at the edge, so a bench change a step later cannot race them
        rst_v = !nrst;
        per_v = period;
        pat_v = pattern;
        if (pcm_valid && pcm_ready) begin
            last_word = pcm_word;
            pops++;
        end
        #1;
        if (rst_v || phase >= per_v - 8'h01) begin
            os_tick = !rst_v;
            bit_v = (pat_v == 2'h0) ? 1'b1 : (pat_v == 2'h1) ? 1'b0 : ~bit_v;
            mod_bit = bit_v;
            phase = 8'h00;
        end else begin
            os_tick = 1'b0;
            mod_bit = ~bit_v;
            phase++;
        end
    end
endmodule

// ---- voiceband_adc_decimator_test.sv ----
// self-checking bench of the voice band decimation chain
`timescale 1ns/1ps

module voiceband_adc_decimator_test;
    // one row: bit pattern and tick spacing beside the settled pcm range
    typedef struct {
        logic [1:0] pat;
        logic [7:0] per;
        int         lo;
        int         hi;
    } vbd_row_t;

    logic               clk;
    logic               nrst;
    logic               egs;
    logic [7:0]         period;
    logic [1:0]         pattern;
    logic               stall;
    logic               os_tick;
    logic               mod_bit;
    logic               pcm_valid;
    logic               pcm_ready;
    logic               pcm_strobe;
    logic               pcm_overrun;
    vbd_pkg::vbd_mode_t input_mode;
    vbd_pkg::vbd_word_t pcm_word;
    vbd_pkg::vbd_word_t last_word;
    int                 pops;
    int                 p0;
    int                 err_total = 0;
    int                 comparisons = 0;
    int                 cyc = 0;
    int                 ticks = 0;
    int                 ticks_at = 0;
    int                 cyc_at = 0;
    int                 gap = 0;
    int                 cgap = 0;
    // all-ones settles near the sinc-cubic full gain times two and all-zeros near minus that; alternating bits settle near zero
    vbd_row_t rows [4] = '{'{2'h0, 8'h02, 31200, 31250}, '{2'h1, 8'h02, -31250, -31200},
                           '{2'h2, 8'h02, -64, 64}, '{2'h0, 8'h05, 31200, 31250}};

    vbd_decimator i_dut (
        .clk                 (clk),
        .nrst                (nrst),
        .os_tick             (os_tick),
        .mod_bit             (mod_bit),
        .external_gain_select(egs),
        .input_mode          (input_mode),
        .pcm_valid           (pcm_valid),
        .pcm_ready           (pcm_ready),
        .pcm_word            (pcm_word),
        .pcm_strobe          (pcm_strobe),
        .pcm_overrun         (pcm_overrun)
    );

    vbd_partner i_partner (
        .clk      (clk),
        .nrst     (nrst),
        .period   (period),
        .pattern  (pattern),
        .stall    (stall),
        .os_tick  (os_tick),
        .mod_bit  (mod_bit),
        .pcm_valid(pcm_valid),
        .pcm_ready(pcm_ready),
        .pcm_word (pcm_word),
        .last_word(last_word),
        .pops     (pops)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // tick and cycle spacing between strobes; a hang ends the run
    always @(posedge clk) begin
        cyc++;
        if (os_tick === 1'b1) ticks++;
        if (pcm_strobe === 1'b1) begin
            gap = ticks - ticks_at;
            cgap = cyc - cyc_at;
            ticks_at = ticks;
            cyc_at = cyc;
        end
        if (cyc == 90000) begin
            err_total++;
            results();
        end
    end

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic check_word(int lo, int hi);
        comparisons++;
        if ((last_word.pcm >= lo && last_word.pcm <= hi) !== 1'b1) begin
            err_total++;
            $display("ERROR pcm expected %0d..%0d seen %0d", lo, hi, last_word.pcm);
        end
    endtask

    task automatic wait_strobe();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (pcm_strobe !== 1'b1 && n < 1000);
        check("strobe_seen", 32'h1, n < 1000);
    endtask

    task automatic results();
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        egs = 1'b1;
        period = 8'h02;
        pattern = 2'h0;
        stall = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check("valid_rst", 32'h0, pcm_valid);
        check("word_rst", 32'h0, pcm_word);
        check("strobe_rst", 32'h0, pcm_strobe);
        check("overrun_rst", 32'h0, pcm_overrun);
        check("mode_rst", vbd_pkg::VBD_MODE_PREAMP, input_mode);
        nrst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("mode_ext", vbd_pkg::VBD_MODE_EXTAMP, input_mode);
        egs = 1'b0;
        @(posedge clk);
        #1;
        check("mode_pre", vbd_pkg::VBD_MODE_PREAMP, input_mode);
        // each row runs long enough for the low-pass cascade to settle
        foreach (rows[i]) begin
            pattern = rows[i].pat;
            period = rows[i].per;
            repeat (36) wait_strobe();
            @(posedge clk);
            #1;
            check_word(rows[i].lo, rows[i].hi);
            check("sat", 32'h0, last_word.sat);
            check("tick_gap", 32'd125, gap);
            check("cycle_gap", 32'd125 * rows[i].per, cgap);
        end
        // stall the receiver: two words held, the third is dropped
        wait_strobe();
        stall = 1'b1;
        wait_strobe();
        check("overrun_1", 32'h0, pcm_overrun);
        check("valid_held", 32'h1, pcm_valid);
        wait_strobe();
        check("overrun_2", 32'h1, pcm_overrun);
        p0 = pops;
        stall = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check("pops", 32'd2, pops - p0);
        check("valid_empty", 32'h0, pcm_valid);
        check_word(31200, 31250);
        results();
    end
endmodule
